// File: rtl/ata_task_file_regs.sv
// task file register bank: error, feature, count, address and unit/head registers
`timescale 1ns/100ps
// Function
// - error detail is read only; bits 5, 3, 1 always read zero
// - bad block event sets error bit 7
// - uncorrectable data event sets error bit 6
// - sector not found event sets error bit 4
// - aborted or invalid command sets error bit 2
// - general failure sets error bit 0
// - offset 1 (byte access) and 0dh (low-lane byte or word access): writes load feature, reads return error detail
// - high-lane write at offset 0 (even enable high, odd low) loads feature
// - a sector count of zero requests 256 sectors
// - successful completion leaves sector count at zero
// - unfinished transfer leaves outstanding sectors in the count
// - start sector register gives sector number or address bits 7-0
// - cylinder low register gives cylinder low byte or address bits 15-8
// - cylinder high register gives cylinder high byte or address bits 23-16
// - unit/head bits 7 and 5 read as one
// - unit/head bit 6 selects geometry (0) or linear (1) addressing
// - unit/head bits 3-0 give head number or address bits 27-24
module ata_task_file_regs
   import ata_task_file_pkg::*;
(
   input  wire logic        ref_clk_in,
   input  wire logic        rst_b_in,
   input  wire logic        ce_in,
   input  wire logic [3:0]  host_addr_in,
   input  wire logic        even_card_enable_n_in,
   input  wire logic        odd_card_enable_n_in,
   input  wire logic        host_rd_in,
   input  wire logic        host_wr_in,
   input  wire logic [15:0] host_data_in,
   output logic      [15:0] host_data_out,
   output logic      [1:0]  host_data_oe_n_out,
   input  wire logic        unit_config_in,
   input  wire logic        cmd_start_in,
   input  wire logic        cmd_done_ok_in,
   input  wire logic        sector_done_in,
   input  wire logic        bad_block_flag_in,
   input  wire logic        uncorrectable_flag_in,
   input  wire logic        sector_not_found_flag_in,
   input  wire logic        command_aborted_flag_in,
   input  wire logic        general_failure_flag_in,
   output logic      [7:0]  error_detail_out,
   output logic      [7:0]  feature_select_out,
   output logic      [7:0]  sector_total_out,
   output logic      [8:0]  sectors_requested_out,
   output logic      [27:0] block_address_out,
   output logic             linear_addressing_select_out,
   output logic             unit_number_select_out
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  error;
      logic [7:0]  feature;
      logic [7:0]  count;
      logic [7:0]  sector;
      logic [7:0]  cyl_lsb;
      logic [7:0]  cyl_msb;
      logic        linear;
      logic        unit;
      logic [3:0]  head;
      logic [15:0] rd_data;
      logic [1:0]  rd_oe_n;
   } state_t;

   state_t      st;
   state_t      next_st;
   logic [3:0]  reg_sel;
   logic        lane_high;
   logic        unit_match;
   logic        wr_hit;
   logic        rd_hit;
   logic [7:0]  wr_byte;
   logic [7:0]  rd_byte;
   logic [7:0]  err_view;
   logic [7:0]  uh_view;

   // ----------------------------------------------------------------
   // access decode
   // ----------------------------------------------------------------
   always_comb begin
      reg_sel   = OFS_NONE;
      lane_high = 1'b0;
      if (!even_card_enable_n_in && odd_card_enable_n_in) begin
         reg_sel = (host_addr_in == OFS_ERROR_DUP) ? OFS_ERROR : host_addr_in;
      end else if (even_card_enable_n_in && !odd_card_enable_n_in) begin
         reg_sel   = {host_addr_in[3:1], 1'b1};
         lane_high = 1'b1;
      end else if (!even_card_enable_n_in && !odd_card_enable_n_in) begin
         if (host_addr_in == OFS_ERROR_DUP) begin
            reg_sel   = OFS_ERROR;
            lane_high = 1'b1;
         end
      end
   end

   always_comb begin
      wr_byte    = lane_high ? host_data_in[15:8] : host_data_in[7:0];
      unit_match = (st.unit == unit_config_in);
      wr_hit     = host_wr_in && (reg_sel >= OFS_ERROR) && (reg_sel <= OFS_UNIT_HEAD)
                   && (unit_match || reg_sel == OFS_UNIT_HEAD);
      rd_hit     = host_rd_in && (reg_sel >= OFS_ERROR) && (reg_sel <= OFS_UNIT_HEAD)
                   && unit_match;
   end

   // ----------------------------------------------------------------
   // read views
   // ----------------------------------------------------------------
   always_comb begin
      err_view = {st.error[ERR_BAD_BLOCK], st.error[ERR_UNCORR], 1'b0,
                  st.error[ERR_NOT_FOUND], 1'b0, st.error[ERR_ABORTED], 1'b0,
                  st.error[ERR_GENERAL]};
      uh_view  = UH_FIXED_MASK | {1'b0, st.linear, 1'b0, st.unit, st.head};
      case (reg_sel)
         OFS_ERROR:     rd_byte = err_view;
         OFS_COUNT:     rd_byte = st.count;
         OFS_SECTOR:    rd_byte = st.sector;
         OFS_CYL_LSB:   rd_byte = st.cyl_lsb;
         OFS_CYL_MSB:   rd_byte = st.cyl_msb;
         OFS_UNIT_HEAD: rd_byte = uh_view;
         default:       rd_byte = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      if (ce_in) begin
         next_st.rd_oe_n = 2'b11;
         if (rd_hit) begin
            next_st.rd_data = lane_high ? {rd_byte, 8'h00} : {8'h00, rd_byte};
            next_st.rd_oe_n = lane_high ? 2'b01 : 2'b10;
         end
         // error flags: cleared at command start, events win
         if (cmd_start_in) begin
            next_st.error = RST_ERROR;
         end
         if (bad_block_flag_in) begin
            next_st.error[ERR_BAD_BLOCK] = 1'b1;
         end
         if (uncorrectable_flag_in) begin
            next_st.error[ERR_UNCORR] = 1'b1;
         end
         if (sector_not_found_flag_in) begin
            next_st.error[ERR_NOT_FOUND] = 1'b1;
         end
         if (command_aborted_flag_in) begin
            next_st.error[ERR_ABORTED] = 1'b1;
         end
         if (general_failure_flag_in) begin
            next_st.error[ERR_GENERAL] = 1'b1;
         end
         // sector count progress
         if (cmd_done_ok_in) begin
            next_st.count = 8'h00;
         end else if (sector_done_in) begin
            next_st.count = st.count - 8'h01;
         end
         if (wr_hit) begin
            case (reg_sel)
               OFS_ERROR:     next_st.feature = wr_byte;
               OFS_COUNT:     next_st.count   = wr_byte;
               OFS_SECTOR:    next_st.sector  = wr_byte;
               OFS_CYL_LSB:   next_st.cyl_lsb = wr_byte;
               OFS_CYL_MSB:   next_st.cyl_msb = wr_byte;
               OFS_UNIT_HEAD: begin
                  next_st.linear = wr_byte[UH_LINEAR];
                  next_st.unit   = wr_byte[UH_UNIT];
                  next_st.head   = wr_byte[3:0];
               end
               default:       next_st.feature = st.feature;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st.error   <= RST_ERROR;
         st.feature <= RST_FEATURE;
         st.count   <= RST_COUNT;
         st.sector  <= RST_ADDR;
         st.cyl_lsb <= RST_ADDR;
         st.cyl_msb <= RST_ADDR;
         st.linear  <= 1'b0;
         st.unit    <= 1'b0;
         st.head    <= RST_HEAD;
         st.rd_data <= 16'h0000;
         st.rd_oe_n <= 2'b11;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   always_comb begin
      host_data_out                = st.rd_data;
      host_data_oe_n_out           = st.rd_oe_n;
      error_detail_out             = err_view;
      feature_select_out           = st.feature;
      sector_total_out             = st.count;
      sectors_requested_out        = (st.count == 8'h00) ? FULL_COUNT : {1'b0, st.count};
      block_address_out            = {st.head, st.cyl_msb, st.cyl_lsb, st.sector};
      linear_addressing_select_out = st.linear;
      unit_number_select_out       = st.unit;
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_b_in);

   sequence s_host_write(logic [3:0] ofs);
      ce_in && wr_hit && reg_sel == ofs;
   endsequence

   sequence s_quiet_count;
      ce_in && !wr_hit && !cmd_done_ok_in;
   endsequence

   a_err_fixed_zero: assert property (error_detail_out[5] == 1'b0 && error_detail_out[3] == 1'b0
                                      && error_detail_out[1] == 1'b0)
      else $error("error detail reserved bit not zero");

   a_bad_block_set: assert property (ce_in && bad_block_flag_in |=> error_detail_out[7])
      else $error("bad block flag not set");

   a_uncorr_sticky: assert property (ce_in && uncorrectable_flag_in ##1 (!ce_in || !cmd_start_in)
                                     |=> error_detail_out[6])
      else $error("uncorrectable flag lost");

   a_not_found_set: assert property (ce_in && sector_not_found_flag_in && cmd_start_in
                                     && !bad_block_flag_in |=> error_detail_out[4] && !error_detail_out[7])
      else $error("sector not found flag not set over clear");

   a_abort_set: assert property (ce_in && command_aborted_flag_in |=> $rose(error_detail_out[2])
                                 || $past(error_detail_out[2]))
      else $error("aborted flag not set");

   a_general_set: assert property (ce_in && general_failure_flag_in |=> error_detail_out[0])
      else $error("general failure flag not set");

   a_feature_write: assert property (s_host_write(OFS_ERROR) |=> feature_select_out
                                     == $past(lane_high ? host_data_in[15:8] : host_data_in[7:0]))
      else $error("feature write not taken");

   a_high_lane_route: assert property (ce_in && host_wr_in && even_card_enable_n_in && !odd_card_enable_n_in
                                       && host_addr_in == OFS_DATA && unit_match
                                       |=> feature_select_out == $past(host_data_in[15:8]))
      else $error("high lane write at offset 0 missed feature");

   a_zero_is_full: assert property (s_host_write(OFS_COUNT) && wr_byte == 8'h00
                                    |=> sectors_requested_out == 9'h100)
      else $error("zero count not read as 256");

   a_done_clears: assert property (ce_in && cmd_done_ok_in && !(wr_hit && reg_sel == OFS_COUNT)
                                   |=> sector_total_out == 8'h00)
      else $error("count not zero after success");

   a_remaining_count: assert property (s_quiet_count ##0 sector_done_in
                                       |=> sector_total_out == $past(sector_total_out) - 8'h01)
      else $error("count not decremented");

   a_address_low: assert property (s_host_write(OFS_SECTOR) |=> block_address_out[7:0] == $past(wr_byte))
      else $error("start sector not loaded");

   a_address_mid_high: assert property (s_host_write(OFS_CYL_LSB) ##1 !(ce_in && wr_hit)
                                        ##1 s_host_write(OFS_CYL_MSB)
                                        |=> block_address_out[23:8] == {$past(wr_byte), $past(wr_byte, 3)})
      else $error("cylinder bytes not loaded");

   a_fixed_ones_read: assert property (ce_in && rd_hit && reg_sel == OFS_UNIT_HEAD && !lane_high
                                       |=> host_data_out[7] && host_data_out[5] && host_data_oe_n_out == 2'b10)
      else $error("unit/head fixed bits not one");

   a_mode_select: assert property (s_host_write(OFS_UNIT_HEAD) |=> linear_addressing_select_out
                                   == $past(wr_byte[6]) && block_address_out[27:24] == $past(wr_byte[3:0]))
      else $error("unit/head write not applied");

   a_foreign_unit: assert property (ce_in && host_rd_in && !unit_match |=> host_data_oe_n_out == 2'b11)
      else $error("card answered another unit");

   sequence s_host_read(logic [3:0] ofs, logic hi);
      ce_in && rd_hit && reg_sel == ofs && lane_high == hi;
   endsequence

   a_error_read_low: assert property (s_host_read(OFS_ERROR, 1'b0)
                                      |=> host_data_out == {8'h00, $past(err_view)} && host_data_oe_n_out == 2'b10)
      else $error("error detail not read on low lane");

   a_error_read_high: assert property (s_host_read(OFS_ERROR, 1'b1)
                                       |=> host_data_out == {$past(err_view), 8'h00} && host_data_oe_n_out == 2'b01)
      else $error("error detail not read on high lane");

   a_uncorr_set: assert property (ce_in && uncorrectable_flag_in
                                  |=> error_detail_out[6])
      else $error("uncorrectable flag not set");

   a_count_write: assert property (s_host_write(OFS_COUNT)
                                   |=> sector_total_out == $past(wr_byte))
      else $error("sector count write not taken");

   a_count_hold: assert property (ce_in && !wr_hit && !cmd_done_ok_in && !sector_done_in
                                  |=> $stable(sector_total_out))
      else $error("sector count changed without cause");

   a_feature_stable: assert property (!(ce_in && wr_hit && reg_sel == OFS_ERROR)
                                      |=> $stable(feature_select_out))
      else $error("feature changed without a write");

   a_foreign_write: assert property (ce_in && host_wr_in && !unit_match && reg_sel != OFS_UNIT_HEAD
                                     |=> $stable(block_address_out[23:0]) && $stable(feature_select_out))
      else $error("write to another unit taken");

   a_unit_write: assert property (s_host_write(OFS_UNIT_HEAD)
                                  |=> unit_number_select_out == $past(wr_byte[4]))
      else $error("unit select not applied");

   a_oe_idle: assert property (ce_in && !rd_hit
                               |=> host_data_oe_n_out == 2'b11)
      else $error("data lanes driven without a read");

   a_sector_read: assert property (s_host_read(OFS_SECTOR, 1'b1)
                                   |=> host_data_out == {$past(block_address_out[7:0]), 8'h00})
      else $error("start sector not read on high lane");

   a_address_mid: assert property (s_host_write(OFS_CYL_LSB)
                                   |=> block_address_out[15:8] == $past(wr_byte))
      else $error("cylinder low byte not loaded");

endmodule : ata_task_file_regs

// File: rtl/ata_task_file_pkg.sv
// constants for the task file register bank
package ata_task_file_pkg;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] OFS_DATA        = 4'h0;
   localparam logic [3:0] OFS_ERROR       = 4'h1;
   localparam logic [3:0] OFS_COUNT       = 4'h2;
   localparam logic [3:0] OFS_SECTOR      = 4'h3;
   localparam logic [3:0] OFS_CYL_LSB     = 4'h4;
   localparam logic [3:0] OFS_CYL_MSB     = 4'h5;
   localparam logic [3:0] OFS_UNIT_HEAD   = 4'h6;
   localparam logic [3:0] OFS_ERROR_DUP   = 4'hd;
   localparam logic [3:0] OFS_NONE        = 4'hf;

   // ----------------------------------------------------------------
   // error detail bit positions
   // ----------------------------------------------------------------
   localparam int         ERR_BAD_BLOCK   = 7;
   localparam int         ERR_UNCORR      = 6;
   localparam int         ERR_NOT_FOUND   = 4;
   localparam int         ERR_ABORTED     = 2;
   localparam int         ERR_GENERAL     = 0;

   // ----------------------------------------------------------------
   // unit/head bit positions and fixed bits
   // ----------------------------------------------------------------
   localparam int         UH_FIXED_HI     = 7;
   localparam int         UH_LINEAR       = 6;
   localparam int         UH_FIXED_LO     = 5;
   localparam int         UH_UNIT         = 4;
   localparam logic [7:0] UH_FIXED_MASK   = 8'ha0;

   // ----------------------------------------------------------------
   // reset values and counts
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_ERROR       = 8'h00;
   localparam logic [7:0] RST_FEATURE     = 8'h00;
   localparam logic [7:0] RST_COUNT       = 8'h01;
   localparam logic [7:0] RST_ADDR        = 8'h00;
   localparam logic [3:0] RST_HEAD        = 4'h0;
   localparam logic [8:0] FULL_COUNT      = 9'h100;

endpackage : ata_task_file_pkg

// File: verification/ata_host_model.sv
// host controller model issuing task file byte and word accesses
`timescale 1ns/100ps
module ata_host_model
   import ata_task_file_pkg::*;
(
   input  wire logic        ref_clk_in,
   input  wire logic [15:0] host_data_in,
   input  wire logic [1:0]  host_data_oe_n_in,
   output logic      [3:0]  addr_out,
   output logic      [1:0]  lane_n_out,
   output logic             rd_out,
   output logic             wr_out,
   output logic      [15:0] data_out
);
   initial begin
      addr_out = OFS_NONE;
      lane_n_out = 2'h3;
      rd_out = 1'b0;
      wr_out = 1'b0;
      data_out = 16'h0000;
   end
   // ----------------------------------------------------------------
   // write: one strobe cycle, then the data lines show the inverse
   // ----------------------------------------------------------------
   task automatic wr(input logic [3:0] a, input logic [1:0] ln, input logic [15:0] d);
      @(posedge ref_clk_in);
      #1;
      addr_out = a;
      lane_n_out = ln;
      data_out = d;
      wr_out = 1'b1;
      @(posedge ref_clk_in);
      #1;
      wr_out = 1'b0;
      lane_n_out = 2'h3;
      data_out = ~d;
   endtask : wr
   // ----------------------------------------------------------------
   // read: one strobe cycle, answer taken as the strobe drops
   // ----------------------------------------------------------------
   task automatic rd(input logic [3:0] a, input logic [1:0] ln, output logic [15:0] d, output logic [1:0] oe);
      @(posedge ref_clk_in);
      #1;
      addr_out = a;
      lane_n_out = ln;
      rd_out = 1'b1;
      @(posedge ref_clk_in);
      #1;
      d = host_data_in;
      oe = host_data_oe_n_in;
      rd_out = 1'b0;
      lane_n_out = 2'h3;
   endtask : rd
endmodule : ata_host_model

// File: verification/ata_task_file_regs_tb_top.sv
// self-checking bench for the task file register bank
`timescale 1ns/100ps
module ata_task_file_regs_tb_top
   import ata_task_file_pkg::*;
;
   localparam logic [1:0] LO = 2'b10;
   localparam logic [1:0] HI = 2'b01;
   logic        ref_clk_in = 1'b0;
   logic        rst_b_in = 1'b0;
   logic        ce_in = 1'b1;
   logic        unit_cfg = 1'b0;
   logic [7:0]  ctl = 8'h00;
   logic [3:0]  addr;
   logic [1:0]  lane_n;
   logic [1:0]  oe_n;
   logic [1:0]  rd_oe;
   logic        rd;
   logic        wr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic [15:0] rd_val;
   logic [7:0]  err;
   logic [7:0]  feat;
   logic [7:0]  cnt;
   logic [8:0]  req;
   logic [27:0] blk;
   logic        lin;
   logic        unit;
   logic [7:0]  ebit [5] = '{8'h01, 8'h04, 8'h10, 8'h40, 8'h80};
   int          n_mismatch = 0;
   int          cmp_count = 0;
   always #20 ref_clk_in = ~ref_clk_in;
   ata_task_file_regs u_ata_task_file_regs (
      .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in), .host_addr_in(addr),
      .even_card_enable_n_in(lane_n[0]), .odd_card_enable_n_in(lane_n[1]), .host_rd_in(rd),
      .host_wr_in(wr), .host_data_in(wdata), .host_data_out(rdata), .host_data_oe_n_out(oe_n),
      .unit_config_in(unit_cfg), .cmd_start_in(ctl[7]), .cmd_done_ok_in(ctl[6]),
      .sector_done_in(ctl[5]), .bad_block_flag_in(ctl[4]), .uncorrectable_flag_in(ctl[3]),
      .sector_not_found_flag_in(ctl[2]), .command_aborted_flag_in(ctl[1]),
      .general_failure_flag_in(ctl[0]), .error_detail_out(err), .feature_select_out(feat),
      .sector_total_out(cnt), .sectors_requested_out(req), .block_address_out(blk),
      .linear_addressing_select_out(lin), .unit_number_select_out(unit));
   ata_host_model u_ata_host_model (
      .ref_clk_in(ref_clk_in), .host_data_in(rdata), .host_data_oe_n_in(oe_n), .addr_out(addr),
      .lane_n_out(lane_n), .rd_out(rd), .wr_out(wr), .data_out(wdata));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [27:0] seen, input logic [27:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic rc(input logic [3:0] a, input logic [1:0] ln, input logic [7:0] e);
      u_ata_host_model.rd(a, ln, rd_val, rd_oe);
      check({rd_oe, rd_val}, (ln == LO) ? {2'b10, 8'h00, e} : {2'b01, e, 8'h00});
   endtask : rc
   task automatic pulse(input logic [7:0] m);
      @(posedge ref_clk_in);
      #1;
      ctl = m;
      @(posedge ref_clk_in);
      #1;
      ctl = 8'h00;
   endtask : pulse
   task automatic conclude;
      $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end
      else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude
   initial begin
      #200000;
      n_mismatch++;
      conclude();
   end
   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge ref_clk_in);
      #1;
      rst_b_in = 1'b1;
      rc(OFS_ERROR, LO, RST_ERROR);
      rc(OFS_COUNT, LO, RST_COUNT);
      rc(OFS_UNIT_HEAD, LO, 8'ha0);
      check(feat, RST_FEATURE);
      $display("test reset done");
      u_ata_host_model.wr(OFS_UNIT_HEAD, LO, 16'h0005);
      rc(OFS_UNIT_HEAD, LO, 8'ha5);
      u_ata_host_model.wr(OFS_UNIT_HEAD, LO, 16'h004c);
      u_ata_host_model.wr(OFS_SECTOR, LO, 16'h0011);
      u_ata_host_model.wr(OFS_CYL_LSB, LO, 16'h0022);
      u_ata_host_model.wr(OFS_CYL_LSB, HI, 16'h3300);
      check(blk, 28'hc332211);
      check(lin, 1'b1);
      rc(OFS_UNIT_HEAD, LO, 8'hec);
      rc(OFS_COUNT, HI, 8'h11);
      $display("test address done");
      u_ata_host_model.wr(OFS_COUNT, LO, 16'h0000);
      check(req, FULL_COUNT);
      pulse(8'h20);
      check(cnt, 8'hff);
      u_ata_host_model.wr(OFS_COUNT, LO, 16'h0003);
      pulse(8'h20);
      check({cnt, req}, {8'h02, 9'h002});
      pulse(8'h60);
      rc(OFS_COUNT, LO, 8'h00);
      $display("test count done");
      for (int i = 0; i < 5; i++) begin
         pulse(8'h80);
         pulse(8'h01 << i);
         check(err, ebit[i]);
      end
      pulse(8'h84);
      check(err, 8'h10);
      pulse(8'h1f);
      rc(OFS_DATA, HI, 8'hd5);
      u_ata_host_model.wr(OFS_ERROR, LO, 16'h005a);
      check({feat, err}, 16'h5ad5);
      u_ata_host_model.wr(OFS_DATA, HI, 16'hc300);
      check(feat, 8'hc3);
      u_ata_host_model.wr(OFS_ERROR_DUP, LO, 16'h0077);
      check(feat, 8'h77);
      rc(OFS_ERROR_DUP, LO, 8'hd5);
      u_ata_host_model.wr(OFS_ERROR_DUP, 2'b00, 16'h6600);
      check(feat, 8'h66);
      u_ata_host_model.wr(OFS_ERROR, 2'b00, 16'h1234);
      check(feat, 8'h66);
      rc(OFS_ERROR_DUP, 2'b00, 8'hd5);
      $display("test error and feature done");
      u_ata_host_model.wr(OFS_UNIT_HEAD, LO, 16'h0010);
      check(unit, 1'b1);
      u_ata_host_model.rd(OFS_SECTOR, LO, rd_val, rd_oe);
      check(rd_oe, 2'b11);
      u_ata_host_model.wr(OFS_SECTOR, LO, 16'h0099);
      check(blk[7:0], 8'h11);
      unit_cfg = 1'b1;
      rc(OFS_SECTOR, LO, 8'h11);
      $display("test unit select done");
      conclude();
   end
endmodule : ata_task_file_regs_tb_top
